// ===== design/sbsf_map.svh
// constants of the brake and status flag block: encodings, positions, lookup data
// assumes inclusion by bare name from files that also see sbsf_pkg
`ifndef SBSF_MAP_SVH
`define SBSF_MAP_SVH

// electrical angle: 4 quadrants of 32 micro positions
`define SBSF_ANGLE_W      7
`define SBSF_QUAD_HI      6
`define SBSF_QUAD_LO      5
`define SBSF_OFF_HI       4
`define SBSF_OFF_W        5
`define SBSF_THETA_FULL   6'h20
`define SBSF_ANGLE_INIT   7'h10
`define SBSF_ANGLE_ZERO   7'h00

// current ratio in percent
`define SBSF_RATIO_W      7
`define SBSF_RATIO_FULL   7'h64
`define SBSF_RATIO_ZERO   7'h00

// step resolution select codes
`define SBSF_RES_STANDBY  3'h0
`define SBSF_RES_FULL     3'h1
`define SBSF_RES_HALF_A   3'h2
`define SBSF_RES_QUARTER  3'h3
`define SBSF_RES_HALF_B   3'h4
`define SBSF_RES_EIGHTH   3'h5
`define SBSF_RES_SIXTEEN  3'h6
`define SBSF_RES_THIRTY2  3'h7

// angle advance per step clock, in micro positions
`define SBSF_INC_32       7'h20
`define SBSF_INC_16       7'h10
`define SBSF_INC_8        7'h08
`define SBSF_INC_4        7'h04
`define SBSF_INC_2        7'h02
`define SBSF_INC_1        7'h01

// ratio per theta index, theta 32 first down to theta 0
`define SBSF_RATIO_LUT {7'h64, 7'h64, 7'h64, 7'h63, 7'h62, 7'h61, 7'h60, 7'h5E, \
                        7'h5C, 7'h5A, 7'h58, 7'h56, 7'h53, 7'h50, 7'h4D, 7'h4A, \
                        7'h47, 7'h43, 7'h3F, 7'h3C, 7'h38, 7'h34, 7'h2F, 7'h2B, \
                        7'h26, 7'h22, 7'h1D, 7'h19, 7'h14, 7'h0F, 7'h0A, 7'h05, 7'h00}

`endif

// ===== design/sbsf_pkg.sv
// types shared by the brake and status flag block
// assumes nothing beyond a SystemVerilog compiler
package sbsf_pkg;

    typedef enum logic [2:0] {
        MODE_STANDBY = 3'b001,
        MODE_RUN     = 3'b010,
        MODE_FAULT   = 3'b100
    } sbsf_mode_e;

    // phase output switch enables, high = transistor conducts
    typedef struct packed {
        logic aPlus;
        logic aMinus;
        logic bPlus;
        logic bMinus;
    } sbsf_drive_s;

    // open-drain flag pull-down enables, high = line pulled low
    typedef struct packed {
        logic initialAngleFlag;
        logic faultFlag;
        logic thermalAlarmFlag;
    } sbsf_flags_s;

    typedef logic [6:0] sbsf_angle_t;

endpackage

// ===== design/sbsf_angle_ctr.sv
// electrical angle counter of the stepper driver
// assumes the step pulse is a one-cycle enable in the clk_sys domain
`timescale 1ns/1ps
`include "sbsf_map.svh"

module sbsf_angle_ctr (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // control
    input  wire logic              stepPulse,
    input  wire logic              dirCw,
    input  wire logic [6:0]        stepInc,
    input  wire logic              home,
    // state
    output sbsf_pkg::sbsf_angle_t  angle
);

    sbsf_pkg::sbsf_angle_t next_angle;

    always_comb begin
        next_angle = angle;
        if (home) begin
            next_angle = `SBSF_ANGLE_INIT;
        end else if (stepPulse) begin
            // wraps modulo one electrical turn
            if (dirCw) begin
                next_angle = angle + stepInc;
            end else begin
                next_angle = angle - stepInc;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            angle <= `SBSF_ANGLE_INIT;
        end else begin
            angle <= next_angle;
        end
    end

endmodule

// ===== design/sbsf_top.sv
// brake handling and status flag logic of a clock-stepped unipolar stepper driver
// assumes all inputs synchronous to clk_sys; flags drive open-drain pads externally
`timescale 1ns/1ps
`include "sbsf_map.svh"

module sbsf_top (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    // host control pins
    input  wire logic                  stepClk,
    input  wire logic                  dirCw,
    input  wire logic                  outputEnable,
    input  wire logic                  brake,
    input  wire logic [2:0]            stepResolutionSelect,
    // analog side indications
    input  wire logic                  currentControlOn,
    input  wire logic                  motorSupplyOk,
    input  wire logic                  thermalShutdown,
    input  wire logic                  overcurrentShutdown,
    input  wire logic                  alarmTempHot,
    input  wire logic                  alarmTempCool,
    // phase drive
    output sbsf_pkg::sbsf_drive_s      drive,
    output logic [6:0]                 ratioA,
    output logic [6:0]                 ratioB,
    // status
    output sbsf_pkg::sbsf_flags_s      flags,
    output sbsf_pkg::sbsf_angle_t      angleOut
);

    localparam logic [32:0][6:0] RATIO_LUT = `SBSF_RATIO_LUT;

    ////////////////////////////////////////////////////////////////////////////////
    // decoding helpers used by the blocks below

    function automatic logic [6:0] stepIncOf(input logic [2:0] sel);
        logic [6:0] inc;
        inc = `SBSF_INC_1;
        unique case (sel)
            `SBSF_RES_FULL:    inc = `SBSF_INC_32;
            `SBSF_RES_HALF_A,
            `SBSF_RES_HALF_B:  inc = `SBSF_INC_16;
            `SBSF_RES_QUARTER: inc = `SBSF_INC_8;
            `SBSF_RES_EIGHTH:  inc = `SBSF_INC_4;
            `SBSF_RES_SIXTEEN: inc = `SBSF_INC_2;
            `SBSF_RES_THIRTY2: inc = `SBSF_INC_1;
            `SBSF_RES_STANDBY: inc = `SBSF_INC_1;
        endcase
        return inc;
    endfunction

    // quadrants 0 and 3 carry positive A, quadrants 0 and 1 positive B
    function automatic logic phasePositive(input sbsf_pkg::sbsf_angle_t ang, input logic isB);
        logic [1:0] q;
        q = ang[`SBSF_QUAD_HI:`SBSF_QUAD_LO];
        return isB ? !q[1] : (q[1] == q[0]);
    endfunction

    function automatic logic [6:0] magnitudeOf(input sbsf_pkg::sbsf_angle_t ang,
                                               input logic isB);
        logic [5:0] off;
        logic [5:0] idx;
        off = {1'b0, ang[`SBSF_OFF_HI:0]};
        // A follows cosine, B follows sine; odd quadrants swap the roles
        if (isB ^ ang[`SBSF_QUAD_LO]) begin
            idx = off;
        end else begin
            idx = `SBSF_THETA_FULL - off;
        end
        return RATIO_LUT[idx];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // step clock edge and standby

    logic                   stepClkPrev;
    logic                   next_stepClkPrev;
    logic                   stepPulse;
    logic                   standby;
    sbsf_pkg::sbsf_angle_t  angle;

    assign standby   = (stepResolutionSelect == `SBSF_RES_STANDBY);
    // brake does not gate the step pulse
    assign stepPulse = stepClk && !stepClkPrev && !standby;

    always_comb begin
        next_stepClkPrev = stepClk;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stepClkPrev <= 1'b0;
        end else begin
            stepClkPrev <= next_stepClkPrev;
        end
    end

    // standby returns the logic to the initial angle
    sbsf_angle_ctr u_angle (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .stepPulse (stepPulse),
        .dirCw     (dirCw),
        .stepInc   (stepIncOf(stepResolutionSelect)),
        .home      (standby),
        .angle     (angle)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // mode and fault latch

    sbsf_pkg::sbsf_mode_e mode;
    sbsf_pkg::sbsf_mode_e next_mode;
    logic                 shutdownEvent;

    assign shutdownEvent = thermalShutdown || overcurrentShutdown;

    always_comb begin
        next_mode = mode;
        // an event in the same cycle as a release keeps the latch set
        if (shutdownEvent) begin
            next_mode = sbsf_pkg::MODE_FAULT;
        end else if (standby || !motorSupplyOk) begin
            next_mode = sbsf_pkg::MODE_STANDBY;
        end else begin
            unique case (mode)
                sbsf_pkg::MODE_STANDBY: next_mode = sbsf_pkg::MODE_RUN;
                sbsf_pkg::MODE_RUN:     next_mode = sbsf_pkg::MODE_RUN;
                sbsf_pkg::MODE_FAULT:   next_mode = sbsf_pkg::MODE_FAULT;
                default:                next_mode = sbsf_pkg::MODE_STANDBY;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode <= sbsf_pkg::MODE_STANDBY;
        end else begin
            mode <= next_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // phase drive and current ratio

    sbsf_pkg::sbsf_drive_s next_drive;
    logic [6:0]            next_ratioA;
    logic [6:0]            next_ratioB;
    logic                  posA;
    logic                  posB;

    assign posA = phasePositive(angle, 1'b0);
    assign posB = phasePositive(angle, 1'b1);

    always_comb begin
        next_drive  = '0;
        next_ratioA = `SBSF_RATIO_ZERO;
        next_ratioB = `SBSF_RATIO_ZERO;
        if (mode == sbsf_pkg::MODE_RUN && outputEnable) begin
            if (brake && !currentControlOn) begin
                next_drive  = '1;
                next_ratioA = `SBSF_RATIO_FULL;
                next_ratioB = `SBSF_RATIO_FULL;
            end else begin
                // sign picks which switch conducts in charge
                next_drive.aPlus  = posA;
                next_drive.aMinus = !posA;
                next_drive.bPlus  = posB;
                next_drive.bMinus = !posB;
                if (brake) begin
                    next_ratioA = `SBSF_RATIO_FULL;
                    next_ratioB = `SBSF_RATIO_FULL;
                end else begin
                    next_ratioA = magnitudeOf(angle, 1'b0);
                    next_ratioB = magnitudeOf(angle, 1'b1);
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            drive  <= '0;
            ratioA <= `SBSF_RATIO_ZERO;
            ratioB <= `SBSF_RATIO_ZERO;
        end else begin
            drive  <= next_drive;
            ratioA <= next_ratioA;
            ratioB <= next_ratioB;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // open-drain status flags

    sbsf_pkg::sbsf_flags_s next_flags;
    sbsf_pkg::sbsf_angle_t next_angleOut;

    always_comb begin
        next_angleOut               = angle;
        next_flags.initialAngleFlag = (angle == `SBSF_ANGLE_INIT);
        next_flags.faultFlag        = (next_mode == sbsf_pkg::MODE_FAULT);
        // hysteresis lives in the sensor; hot wins if both indications assert
        if (alarmTempHot) begin
            next_flags.thermalAlarmFlag = 1'b1;
        end else if (alarmTempCool) begin
            next_flags.thermalAlarmFlag = 1'b0;
        end else begin
            next_flags.thermalAlarmFlag = flags.thermalAlarmFlag;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flags    <= '0;
            angleOut <= `SBSF_ANGLE_INIT;
        end else begin
            flags    <= next_flags;
            angleOut <= next_angleOut;
        end
    end

endmodule

// ===== sim/sbsf_flag_monitor.sv
// port assertions for the brake and status flag block
// assumes binding into sbsf_top; one clock domain, clk_sys
`timescale 1ns/1ps

module sbsf_flag_monitor (
    // clock and reset
    input wire logic                  clk_sys,
    input wire logic                  resetn,
    // control inputs
    input wire logic                  outputEnable,
    input wire logic                  brake,
    input wire logic [2:0]            stepResolutionSelect,
    input wire logic                  currentControlOn,
    input wire logic                  motorSupplyOk,
    input wire logic                  thermalShutdown,
    input wire logic                  overcurrentShutdown,
    input wire logic                  alarmTempHot,
    input wire logic                  alarmTempCool,
    // outputs watched
    input wire sbsf_pkg::sbsf_drive_s drive,
    input wire logic [6:0]            ratioA,
    input wire logic [6:0]            ratioB,
    input wire sbsf_pkg::sbsf_flags_s flags,
    input wire sbsf_pkg::sbsf_angle_t angleOut
);
    logic runOk;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // outputs only defined once run mode has been reachable for a few edges
    assign runOk = outputEnable && (stepResolutionSelect != 3'h0) && motorSupplyOk
                   && !flags.faultFlag && !thermalShutdown && !overcurrentShutdown;

    ////////////////////////////////////////////////////////////////////////////////
    init_flag_a: assert property ((stepResolutionSelect != 3'h0)[*3] |->
        flags.initialAngleFlag == (angleOut == 7'h10)) else $error("initial flag wrong");
    standby_angle_a: assert property ((stepResolutionSelect == 3'h0)[*3] |->
        angleOut == 7'h10) else $error("standby angle not initial");
    fault_set_a: assert property (thermalShutdown || overcurrentShutdown |=>
        flags.faultFlag) else $error("fault flag not set");
    fault_hold_a: assert property (flags.faultFlag && stepResolutionSelect != 3'h0 &&
        motorSupplyOk |=> flags.faultFlag) else $error("fault flag dropped");
    fault_clear_a: assert property ((stepResolutionSelect == 3'h0 || !motorSupplyOk) &&
        !thermalShutdown && !overcurrentShutdown |=> !flags.faultFlag)
        else $error("fault flag not cleared");
    alarm_set_a: assert property (alarmTempHot |=> flags.thermalAlarmFlag)
        else $error("alarm flag not set");
    alarm_clear_a: assert property (alarmTempCool && !alarmTempHot |=>
        !flags.thermalAlarmFlag) else $error("alarm flag not released");
    brake_full_a: assert property ((brake && currentControlOn && runOk)[*3] |->
        ratioA == 7'h64 && ratioB == 7'h64) else $error("brake ratio not full");
    brake_sign_a: assert property ((brake && currentControlOn && runOk)[*3] |->
        drive.aPlus == (angleOut[6:5] == 2'h0 || angleOut[6:5] == 2'h3)
        && drive.aMinus == !drive.aPlus && drive.bPlus == !angleOut[6]
        && drive.bMinus == angleOut[6]) else $error("brake polarity wrong");
    brake_all_on_a: assert property ((brake && !currentControlOn && runOk)[*3] |->
        drive == 4'hF) else $error("brake switches not all on");
endmodule

bind sbsf_top sbsf_flag_monitor i_sbsf_flag_monitor (
    .clk_sys(clk_sys), .resetn(resetn), .outputEnable(outputEnable), .brake(brake),
    .stepResolutionSelect(stepResolutionSelect), .currentControlOn(currentControlOn),
    .motorSupplyOk(motorSupplyOk), .thermalShutdown(thermalShutdown),
    .overcurrentShutdown(overcurrentShutdown), .alarmTempHot(alarmTempHot),
    .alarmTempCool(alarmTempCool), .drive(drive), .ratioA(ratioA), .ratioB(ratioB),
    .flags(flags), .angleOut(angleOut));

// ===== sim/sbsf_host_model.sv
// host side step clock generator
// assumes a one-cycle stepReq from the bench while busy is low
`timescale 1ns/1ps

module sbsf_host_model (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // bench request
    input  wire logic stepReq,
    // host pins
    output logic      stepClk,
    output logic      busy
);
    logic [1:0] cnt;

    // two cycles high then at least three low, so each pulse is seen as one edge
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stepClk <= 1'b0;
            busy    <= 1'b0;
            cnt     <= 2'h0;
        end else if (!busy) begin
            stepClk <= stepReq;
            busy    <= stepReq;
            cnt     <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'h1) stepClk <= 1'b0;
            if (cnt == 2'h3) busy <= 1'b0;
        end
    end
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the brake and status flag block
// assumes the host model supplies step pulses; the initial angle flag read through a pull-up
`timescale 1ns/1ps

module tb_top;
    logic clk_sys = 1'b0, resetn, stepClk, stepReq, dirCw, outputEnable, brake, busy;
    logic [2:0] stepResolutionSelect;
    logic currentControlOn, motorSupplyOk, thermalShutdown, overcurrentShutdown;
    logic alarmTempHot, alarmTempCool, pinInit;
    sbsf_pkg::sbsf_drive_s drive;
    sbsf_pkg::sbsf_flags_s flags;
    sbsf_pkg::sbsf_angle_t angleOut;
    logic [6:0] ratioA, ratioB;
    logic [6:0] incs [8] = '{7'h00, 7'h20, 7'h10, 7'h08, 7'h10, 7'h04, 7'h02, 7'h01};
    logic [3:0] quad [4] = '{4'hA, 4'h6, 4'h5, 4'h9};
    int numErrors = 0, comparisons = 0, cycles = 0, c;

    ////////////////////////////////////////////////////////////////////////////////
    initial forever #5 clk_sys = ~clk_sys;
    // open-drain line with external pull-up
    assign pinInit = flags.initialAngleFlag ? 1'b0 : 1'b1;

    sbsf_top i_sbsf_top (.clk_sys(clk_sys), .resetn(resetn), .stepClk(stepClk),
        .dirCw(dirCw), .outputEnable(outputEnable), .brake(brake),
        .stepResolutionSelect(stepResolutionSelect), .currentControlOn(currentControlOn),
        .motorSupplyOk(motorSupplyOk), .thermalShutdown(thermalShutdown),
        .overcurrentShutdown(overcurrentShutdown), .alarmTempHot(alarmTempHot),
        .alarmTempCool(alarmTempCool), .drive(drive), .ratioA(ratioA), .ratioB(ratioB),
        .flags(flags), .angleOut(angleOut));
    sbsf_host_model i_sbsf_host_model (.clk_sys(clk_sys), .resetn(resetn),
        .stepReq(stepReq), .stepClk(stepClk), .busy(busy));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [6:0] got, input logic [6:0] exp);
        comparisons++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic stepOnce();
        int n;
        n = 0;
        @(posedge clk_sys);
        stepReq <= 1'b1;
        @(posedge clk_sys);
        stepReq <= 1'b0;
        @(negedge clk_sys);
        while (busy === 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        wt(3);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, numErrors);
        if (numErrors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ceiling far above the few hundred cycles the tests take
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            numErrors++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0; stepReq = 1'b0; dirCw = 1'b1; outputEnable = 1'b1; brake = 1'b0;
        stepResolutionSelect = 3'h1; currentControlOn = 1'b1; motorSupplyOk = 1'b1;
        thermalShutdown = 1'b0; overcurrentShutdown = 1'b0;
        alarmTempHot = 1'b0; alarmTempCool = 1'b1;
        wt(6);
        chk(angleOut, 7'h10);
        chk({4'h0, flags}, 7'h00);
        chk({3'h0, drive}, 7'h00);
        @(posedge clk_sys);
        resetn <= 1'b1;
        brake <= 1'b1;
        wt(4);
        $display("test reset done");
        for (c = 0; c < 4; c++) begin
            chk({3'h0, drive}, {3'h0, quad[c]});
            chk(ratioA, 7'h64);
            chk(ratioB, 7'h64);
            stepOnce();
        end
        chk(angleOut, 7'h10);
        chk({6'h0, pinInit}, 7'h00);
        @(posedge clk_sys);
        currentControlOn <= 1'b0;
        wt(3);
        chk({3'h0, drive}, 7'h0F);
        // output disable must win over the all-on brake drive
        @(posedge clk_sys);
        outputEnable <= 1'b0;
        wt(3);
        chk({3'h0, drive}, 7'h00);
        @(posedge clk_sys);
        outputEnable <= 1'b1;
        @(posedge clk_sys);
        currentControlOn <= 1'b1;
        brake <= 1'b0;
        wt(3);
        chk(ratioA, 7'h47);
        chk({3'h0, drive}, 7'h0A);
        $display("test brake done");
        for (c = 1; c < 8; c++) begin
            @(posedge clk_sys);
            stepResolutionSelect <= 3'h0;
            brake <= c[0];
            wt(3);
            chk(angleOut, 7'h10);
            @(posedge clk_sys);
            stepResolutionSelect <= c[2:0];
            wt(3);
            stepOnce();
            chk(angleOut, 7'h10 + incs[c]);
            chk({6'h0, pinInit}, 7'h01);
        end
        @(posedge clk_sys);
        dirCw <= 1'b0;
        stepOnce();
        chk(angleOut, 7'h10);
        $display("test steps done");
        for (c = 0; c < 2; c++) begin
            @(posedge clk_sys);
            {thermalShutdown, overcurrentShutdown} <= c[0] ? 2'h1 : 2'h2;
            @(posedge clk_sys);
            {thermalShutdown, overcurrentShutdown} <= 2'h0;
            wt(4);
            chk({6'h0, flags.faultFlag}, 7'h01);
            chk({3'h0, drive}, 7'h00);
            @(posedge clk_sys);
            if (c == 0) stepResolutionSelect <= 3'h0;
            else motorSupplyOk <= 1'b0;
            wt(2);
            chk({6'h0, flags.faultFlag}, 7'h00);
            @(posedge clk_sys);
            stepResolutionSelect <= 3'h7;
            motorSupplyOk <= 1'b1;
            wt(3);
        end
        $display("test fault done");
        @(posedge clk_sys);
        alarmTempCool <= 1'b0;
        alarmTempHot <= 1'b1;
        wt(2);
        chk({6'h0, flags.thermalAlarmFlag}, 7'h01);
        @(posedge clk_sys);
        alarmTempHot <= 1'b0;
        wt(3);
        chk({6'h0, flags.thermalAlarmFlag}, 7'h01);
        @(posedge clk_sys);
        alarmTempCool <= 1'b1;
        wt(2);
        chk({6'h0, flags.thermalAlarmFlag}, 7'h00);
        $display("test alarm done");
        conclude();
    end
endmodule
